// File: flash_boot_select_isp_loader_bench.sv
// Purpose: self-checking bench for boot select, fetch decode and hex loader
// Assumes: host at 16 clocks per bit; flash answers 3 cycles after a strobe
// Notes: expected characters are built here from the record fields
`timescale 1ns/1ps
module flash_boot_select_isp_loader_bench;
  import isp_pkg::*;
  localparam int BIT = 16;
  localparam logic [15:0] CORNER [8] = '{16'h0000, 16'h1fff, 16'h2000, 16'h3fff,
                                          16'h4000, 16'hfbff, 16'hfc00, 16'hffff};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic fetch_n = 1'b1, bit7 = 1'b0, bit6 = 1'b0, ext_strap = 1'b1, ale = 1'b1;
  logic rom_en = 1'b0, fail_byte = 1'b0, prog_done = 1'b0;
  logic rxd, txd, fetch_rom, fetch_ext, prog_strobe;
  logic [15:0] fetch_addr = 16'h0000;
  logic [15:0] start_addr, prog_addr, a;
  logic [2:0] fetch_block;
  logic [2:0] dly = 3'h0;
  logic [7:0] prog_data, osc_mhz, status_byte, boot_vector;
  logic [23:0] pq[$];
  logic [7:0] eq[$];
  logic [7:0] dat[0:16];
  int n_fail = 0, cmp_count = 0, cycles = 0;
  wire prog_ok = ~fail_byte;
  always #20 clock = ~clock;
  isp_host #(.BIT(BIT)) host (.clock(clock), .rxd(rxd), .txd(txd));
  isp_loader dut (
    .CLOCK(clock), .RSTN(rstn), .RXD(rxd), .TXD(txd),
    .PROGRAM_FETCH_STROBE_N(fetch_n), .UPPER_PORT_BIT_SEVEN(bit7),
    .UPPER_PORT_BIT_SIX(bit6), .EXTERNAL_ACCESS_STRAP(ext_strap), .ADDRESS_LATCH(ale),
    .BOOT_ROM_ENABLE(rom_en), .FETCH_ADDR(fetch_addr), .START_ADDR(start_addr),
    .FETCH_BOOT_ROM(fetch_rom), .FETCH_EXTERNAL(fetch_ext), .FETCH_BLOCK(fetch_block),
    .PROG_STROBE(prog_strobe), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
    .PROG_DONE(prog_done), .PROG_OK(prog_ok), .OSC_MHZ(osc_mhz),
    .STATUS_BYTE(status_byte), .BOOT_VECTOR(boot_vector)
  );
  // flash array stand-in: logs every strobe, answers a fixed 3 cycles later
  always @(posedge clock) begin
    prog_done <= #1 (dly == 3'h1);
    dly <= #1 prog_strobe ? 3'h3 : (dly != 3'h0) ? dly - 3'h1 : 3'h0;
    if (prog_strobe === 1'b1) pq.push_back({prog_addr, prog_data});
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  function automatic logic [15:0] blk(input logic [15:0] x);
    return x < BLOCK1_BASE ? 16'h0 : x < BLOCK2_BASE ? 16'h1 : x < BLOCK3_BASE ? 16'h2 :
           x < BLOCK4_BASE ? 16'h3 : 16'h4;
  endfunction
  task automatic do_reset(input logic [4:0] s, input logic [15:0] exp);
    @(posedge clock);
    #1;
    rstn = 1'b0;
    {fetch_n, bit7, bit6, ext_strap, ale} = s;
    repeat (2) @(posedge clock);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk(start_addr, exp);
  endtask
  // eq may already hold prefix characters that the loader must echo and skip
  task automatic rec(input logic [7:0] typ, input logic [15:0] adr, input int n,
                     input logic [7:0] flip, input logic [7:0] reply);
    logic [7:0] b[$];
    logic [7:0] s;
    b = {8'(n), adr[15:8], adr[7:0], typ};
    for (int i = 0; i < n; i++) b.push_back(dat[i]);
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    b.push_back((8'h00 - s) ^ flip);
    eq.push_back(CH_COLON);
    foreach (b[i]) begin
      eq.push_back(hx(b[i][7:4]));
      eq.push_back(hx(b[i][3:0]));
    end
    foreach (eq[i]) host.send_byte(eq[i]);
    if (reply != 8'h00) eq.push_back(reply);
    for (int i = 0; i < 40 * BIT && host.rx_q.size() < eq.size(); i++) @(posedge clock);
    repeat (24 * BIT) @(posedge clock);
    chk(16'(host.rx_q.size()), 16'(eq.size()));
    foreach (eq[i]) if (i < host.rx_q.size()) chk(16'(host.rx_q[i]), 16'(eq[i]));
    host.rx_q.delete();
    eq.delete();
    host.send_byte(8'h0d);
    host.send_byte(8'h0a);
    repeat (12 * BIT) @(posedge clock);
    host.rx_q.delete();
  endtask
  task automatic wr(input logic [7:0] ss, input logic [7:0] dd);
    dat[0] = SUB_PROG_BV;
    dat[1] = ss;
    dat[2] = dd;
    rec(REC_WRITE, 16'h0000, 3, 8'h00, CH_DOT);
  endtask
  initial begin
    void'($urandom(43));
    do_reset(5'b10011, {BOOT_VECTOR_RESET, START_LOW});
    chk(16'(boot_vector), 16'(BOOT_VECTOR_RESET));
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      #1;
      fetch_addr = (i < 8) ? CORNER[i] : 16'($urandom);
      rom_en = 1'($urandom);
      repeat (2) @(posedge clock);
      #1;
      chk(16'(fetch_block), blk(fetch_addr));
      chk(16'(fetch_rom), 16'(rom_en && fetch_addr >= BOOTROM_BASE));
      chk(16'(fetch_ext), 16'h0000);
    end
    host.send_byte(CH_U);
    repeat (14 * BIT) @(posedge clock);
    chk(16'(host.rx_q.size()), 16'h0001);
    chk(16'(host.rx_q[0]), 16'(CH_U));
    host.rx_q.delete();
    dat[0] = 8'($urandom);
    rec(REC_OSC, 16'h0000, 1, 8'h00, CH_DOT);
    chk(16'(osc_mhz), 16'(dat[0]));
    a = 16'($urandom) & 16'h7fff;
    for (int i = 0; i < 17; i++) dat[i] = 8'($urandom);
    pq.delete();
    rec(REC_DATA, a, 16, 8'h00, CH_DOT);
    chk(16'(pq.size()), 16'h0010);
    foreach (pq[i]) chk(pq[i][23:8], a + 16'(i));
    foreach (pq[i]) chk(16'(pq[i][7:0]), 16'(dat[i]));
    fail_byte = 1'b1;
    rec(REC_DATA, a, 2, 8'h00, CH_R);
    fail_byte = 1'b0;
    pq.delete();
    rec(REC_DATA, a, 1, 8'h01, CH_X);
    rec(REC_DATA, a, 17, 8'h00, 8'h00);
    chk(16'(pq.size()), 16'h0000);
    eq = {8'h47, CH_COLON, hx(4'h1)};
    rec(REC_EOF, 16'h0000, 0, 8'h00, CH_DOT);
    rec(REC_DISPLAY, 16'h0000, 0, 8'h00, CH_DOT);
    dat[0] = SUB_ERASE_BV;
    dat[1] = 8'h00;
    rec(REC_WRITE, 16'h0000, 2, 8'h00, CH_DOT);
    chk(16'(status_byte), 16'h0000);
    chk(16'(boot_vector), 16'h0000);
    wr(8'h01, BOOT_VECTOR_RESET);
    chk(16'(boot_vector), 16'(BOOT_VECTOR_RESET));
    wr(8'h00, 8'h00);
    chk(16'(status_byte), 16'h0000);
    do_reset(5'b10011, 16'h0000);
    do_reset(5'b01111, {BOOT_VECTOR_RESET, START_LOW});
    do_reset(5'b10001, 16'h0000);
    chk(16'(fetch_ext), 16'h0001);
    end_sim();
  end
endmodule

// File: isp_hex.sv
// Purpose: ascii hex digit to nibble
// Assumes: upper or lower case digits
// Notes: bad flags any non-hex character
`timescale 1ns/1ps
module isp_hex (
  input wire logic [7:0] ch,
  output logic [3:0] nib,
  output logic bad
);
  always_comb begin
    bad = 1'b0;
    nib = 4'h0;
    if (ch >= 8'h30 && ch <= 8'h39) nib = 4'(ch - 8'h30);
    else if (ch >= 8'h41 && ch <= 8'h46) nib = 4'(ch - 8'h37);
    else if (ch >= 8'h61 && ch <= 8'h66) nib = 4'(ch - 8'h57);
    else bad = 1'b1;
  end
endmodule

// File: isp_host.sv
// Purpose: host programmer model on the serial link
// Assumes: 8N1 framing, idle-high lines, fixed bit time in clocks
// Notes: characters coming back collect in rx_q for the bench
`timescale 1ns/1ps
module isp_host #(
  parameter int BIT = 16
)(
  input wire logic clock,
  output logic rxd,
  input wire logic txd
);
  logic [7:0] rx_q[$];
  logic [7:0] b;
  initial rxd = 1'b1;
  // start, lsb first, stop, then one idle bit so the loader can echo
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      rxd <= #1 (i == 0) ? 1'b0 : (i < 9) ? v[i-1] : 1'b1;
      repeat (BIT - 1) @(posedge clock);
    end
  endtask
  // sample mid-bit; tolerates a loader bit time less than one clock off
  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock);
        b[i] = txd;
      end
      repeat (BIT) @(posedge clock);
      rx_q.push_back(b);
    end
  end
endmodule

// File: isp_loader.sv
// Purpose: boot start selection, fetch overlay and serial hex loader
// Assumes: flash array lives outside; this block issues program strobes
// Notes: one record buffered at a time
// Operation
// - program flash split into two 8k blocks then three 16k blocks.
// - enabled boot ROM overlays fetches from FC00 to FFFF.
// - external-access strap low sends all fetches to external memory.
// - zero status byte at reset release starts at 0000.
// - nonzero status byte starts at boot vector high byte, 00 low.
// - boot vector defaults to FC, entering the loader at FC00.
// - erasing status byte or boot vector clears both.
// - pin strap combination at reset forces loader entry.
// - host sends U; loader times one bit to set baud.
// - every received character is echoed.
// - after baud setup only colon-led hex records are parsed.
// - records carry at most sixteen data bytes.
// - type 00 programs data, 01 ends file, others are commands.
// - record buffered with running checksum; acted on only when complete.
// - checksum mismatch sends X and skips the command.
// - successful record answered with a period.
// - data record with a failed byte answers R instead.
// - oscillator record byte is whole megahertz for pulse timing.
`timescale 1ns/1ps
module isp_loader
  import isp_pkg::*;
#(
  parameter int DATA_MAX = MAX_DATA
)(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic RXD,
  output logic TXD,
  input wire logic PROGRAM_FETCH_STROBE_N,
  input wire logic UPPER_PORT_BIT_SEVEN,
  input wire logic UPPER_PORT_BIT_SIX,
  input wire logic EXTERNAL_ACCESS_STRAP,
  input wire logic ADDRESS_LATCH,
  input wire logic BOOT_ROM_ENABLE,
  input wire logic [15:0] FETCH_ADDR,
  output logic [15:0] START_ADDR,
  output logic FETCH_BOOT_ROM,
  output logic FETCH_EXTERNAL,
  output logic [2:0] FETCH_BLOCK,
  output logic PROG_STROBE,
  output logic [15:0] PROG_ADDR,
  output logic [7:0] PROG_DATA,
  input wire logic PROG_DONE,
  input wire logic PROG_OK,
  output logic [7:0] OSC_MHZ,
  output logic [7:0] STATUS_BYTE,
  output logic [7:0] BOOT_VECTOR
);
  if (DATA_MAX < 1 || DATA_MAX > 16) begin : g_bad_max
    $error("DATA_MAX out of range");
  end
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_HI = 3'b001, S_LO = 3'b011, S_EXEC = 3'b010,
    S_PROG = 3'b110, S_WAIT = 3'b111, S_REPLY = 3'b101
  } state_t;
  isp_uart_if u();
  isp_uart ser (.clock(CLOCK), .rstn(RSTN), .rxd(RXD), .txd(TXD), .u(u));
  logic [3:0] nib;
  logic hexbad;
  isp_hex hx (.ch(u.rx_data), .nib(nib), .bad(hexbad));
  logic [7:0] buf_q [0:DATA_MAX+HDR_BYTES];
  logic [7:0] buf_d [0:DATA_MAX+HDR_BYTES];
  state_t st_q, st_d;
  logic [4:0] idx_q, idx_d, pidx_q, pidx_d;
  logic [3:0] hi_q, hi_d;
  logic [7:0] sum_q, sum_d, stat_d, bv_d, osc_q, osc_d, reply_q, reply_d;
  // nonvolatile bytes survive reset; power-up value is factory default
  logic [7:0] stat_q = STATUS_RESET;
  logic [7:0] bv_q = BOOT_VECTOR_RESET;
  logic fail_q, fail_d, echo_q, echo_d, pend_q, pend_d, strobe_q, strobe_d;
  logic [15:0] start_q, start_d, paddr_q, paddr_d;
  logic [7:0] pdata_q, pdata_d;
  logic rst_seen_q, rom_q, ext_q;
  logic [2:0] blk_q;
  logic [7:0] bytev, cnt;
  logic strap_force;
  assign bytev = {hi_q, nib};
  assign cnt = buf_q[0];
  assign strap_force = !PROGRAM_FETCH_STROBE_N && UPPER_PORT_BIT_SEVEN && UPPER_PORT_BIT_SIX
                       && EXTERNAL_ACCESS_STRAP && ADDRESS_LATCH;
  always_comb begin
    stat_d = stat_q; bv_d = bv_q; start_d = start_q;
    // start address chosen once, at the first edge after reset release
    if (!rst_seen_q) begin
      if (stat_q == 8'h00 && !strap_force) start_d = 16'h0000;
      else start_d = {bv_q, START_LOW};
    end
    st_d = st_q; idx_d = idx_q; hi_d = hi_q; sum_d = sum_q; fail_d = fail_q;
    osc_d = osc_q; reply_d = reply_q; pidx_d = pidx_q; strobe_d = 1'b0;
    paddr_d = paddr_q; pdata_d = pdata_q;
    buf_d = buf_q;
    echo_d = echo_q; pend_d = pend_q;
    // echo takes the transmitter first; replies wait behind it
    if (u.rx_valid) echo_d = 1'b1;
    else if (echo_q && !u.tx_busy) echo_d = 1'b0;
    if (u.rx_valid && u.rx_data == CH_COLON && st_q != S_PROG && st_q != S_WAIT) begin
      st_d = S_HI; idx_d = 5'd0; sum_d = 8'h00; fail_d = 1'b0;
    end else begin
      case (st_q)
        S_IDLE: ; // non-colon characters dropped
        S_HI: if (u.rx_valid) begin
          if (hexbad) st_d = S_IDLE;
          else begin
            hi_d = nib; st_d = S_LO;
          end
        end
        S_LO: if (u.rx_valid) begin
          if (hexbad) st_d = S_IDLE;
          else begin
            buf_d[idx_q] = bytev;
            sum_d = sum_q + bytev;
            idx_d = idx_q + 5'd1;
            st_d = S_HI;
            if (idx_q == 5'd0 && bytev > 8'(DATA_MAX)) st_d = S_IDLE;
            else if (idx_q != 5'd0 && {3'b000, idx_q} == cnt + 8'(HDR_BYTES)) st_d = S_EXEC;
          end
        end
        S_EXEC: begin
          // whole record in hand before anything acts
          if (sum_q != 8'h00) begin
            reply_d = CH_X; st_d = S_REPLY;
          end else begin
            reply_d = CH_DOT; st_d = S_REPLY;
            case (buf_q[3])
              REC_DATA: begin
                pidx_d = 5'd0; st_d = (cnt == 8'h00) ? S_REPLY : S_PROG;
              end
              REC_EOF: ;
              REC_OSC: osc_d = buf_q[4];
              REC_WRITE: begin
                if (buf_q[4] == SUB_ERASE_BV) begin
                  stat_d = 8'h00; bv_d = 8'h00; // erased together
                end else if (buf_q[4] == SUB_PROG_BV) begin
                  if (buf_q[5] == 8'h00) stat_d = buf_q[6];
                  else bv_d = buf_q[6];
                end
              end
              default: ; // display and others not handled here
            endcase
          end
        end
        S_PROG: begin
          paddr_d = {buf_q[1], buf_q[2]} + 16'(pidx_q);
          pdata_d = buf_q[5'd4 + pidx_q];
          strobe_d = 1'b1;
          st_d = S_WAIT;
        end
        S_WAIT: if (PROG_DONE) begin
          if (!PROG_OK) fail_d = 1'b1;
          pidx_d = pidx_q + 5'd1;
          st_d = ({3'b000, pidx_q} + 8'h01 == cnt) ? S_REPLY : S_PROG;
        end
        S_REPLY: begin
          if (fail_q) reply_d = CH_R;
          pend_d = 1'b1;
          st_d = S_IDLE;
        end
        default: st_d = S_IDLE;
      endcase
    end
    if (pend_q && !echo_q && !u.tx_busy && !u.rx_valid) pend_d = 1'b0;
  end
  always_comb begin
    u.tx_start = 1'b0;
    u.tx_data = u.rx_data;
    if (echo_q && !u.tx_busy) u.tx_start = 1'b1;
    else if (pend_q && !u.tx_busy && !u.rx_valid) begin
      u.tx_start = 1'b1; u.tx_data = reply_q;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_q <= S_IDLE; idx_q <= 5'd0; hi_q <= 4'h0; sum_q <= 8'h00; fail_q <= 1'b0;
      osc_q <= 8'h00; reply_q <= CH_DOT; pidx_q <= 5'd0; strobe_q <= 1'b0;
      paddr_q <= 16'h0000; pdata_q <= 8'h00; echo_q <= 1'b0; pend_q <= 1'b0;
      start_q <= 16'h0000; rst_seen_q <= 1'b0;
      for (int i = 0; i <= DATA_MAX + HDR_BYTES; i++) buf_q[i] <= 8'h00;
    end else begin
      st_q <= st_d; idx_q <= idx_d; hi_q <= hi_d; sum_q <= sum_d; fail_q <= fail_d;
      osc_q <= osc_d; reply_q <= reply_d; pidx_q <= pidx_d; strobe_q <= strobe_d;
      paddr_q <= paddr_d; pdata_q <= pdata_d; echo_q <= echo_d; pend_q <= pend_d;
      start_q <= start_d; rst_seen_q <= 1'b1;
      buf_q <= buf_d;
    end
  end
  always_ff @(posedge CLOCK) begin
    stat_q <= stat_d;
    bv_q <= bv_d;
  end
  // fetch decode
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      rom_q <= 1'b0; ext_q <= 1'b0; blk_q <= 3'd0;
    end else begin
      ext_q <= !EXTERNAL_ACCESS_STRAP;
      rom_q <= EXTERNAL_ACCESS_STRAP && BOOT_ROM_ENABLE && FETCH_ADDR >= BOOTROM_BASE;
      if (FETCH_ADDR < BLOCK1_BASE) blk_q <= 3'd0;
      else if (FETCH_ADDR < BLOCK2_BASE) blk_q <= 3'd1;
      else if (FETCH_ADDR < BLOCK3_BASE) blk_q <= 3'd2;
      else if (FETCH_ADDR < BLOCK4_BASE) blk_q <= 3'd3;
      else blk_q <= 3'd4;
    end
  end
  assign START_ADDR = start_q;
  assign FETCH_BOOT_ROM = rom_q;
  assign FETCH_EXTERNAL = ext_q;
  assign FETCH_BLOCK = blk_q;
  assign PROG_STROBE = strobe_q;
  assign PROG_ADDR = paddr_q;
  assign PROG_DATA = pdata_q;
  assign OSC_MHZ = osc_q;
  assign STATUS_BYTE = stat_q;
  assign BOOT_VECTOR = bv_q;
  start_sel_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !$past(rst_seen_q) && rst_seen_q && $past(stat_q) == 8'h00 && !$past(strap_force)
    |-> start_q == 16'h0000) else $error("start address not zero");
  vector_sel_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !$past(rst_seen_q) && rst_seen_q && ($past(stat_q) != 8'h00 || $past(strap_force))
    |-> start_q == {$past(bv_q), 8'h00}) else $error("start address not vector");
  bad_sum_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_q == S_EXEC && sum_q != 8'h00 |=> st_q == S_REPLY && reply_q == CH_X && !strobe_q)
    else $error("bad checksum not refused");
  prog_fail_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_q == S_WAIT && PROG_DONE && !PROG_OK |=> fail_q) else $error("fail lost");
  erase_pair_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    st_q == S_EXEC && sum_q == 8'h00 && buf_q[3] == REC_WRITE && buf_q[4] == SUB_ERASE_BV
    |=> stat_q == 8'h00 && bv_q == 8'h00) else $error("erase not paired");
  colon_restart_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    u.rx_valid && u.rx_data == CH_COLON && st_q inside {S_IDLE, S_HI, S_LO}
    |=> st_q == S_HI && idx_q == 5'd0 && sum_q == 8'h00) else $error("no restart");
  echo_out_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    u.rx_valid |=> echo_q) else $error("echo missed");
  overlay_map_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    EXTERNAL_ACCESS_STRAP && BOOT_ROM_ENABLE && FETCH_ADDR[15:10] == 6'h3f |=> rom_q)
    else $error("overlay missing");
endmodule

// File: isp_pkg.sv
// Purpose: shared constants for the boot-select and serial loader block
// Assumes: 25 MHz system clock, 8N1 serial framing
// Notes: ascii codes and record types live here
package isp_pkg;
  localparam int CLK_HZ = 25000000;
  localparam logic [15:0] BLOCK1_BASE = 16'h2000;
  localparam logic [15:0] BLOCK2_BASE = 16'h4000;
  localparam logic [15:0] BLOCK3_BASE = 16'h8000;
  localparam logic [15:0] BLOCK4_BASE = 16'hc000;
  localparam logic [15:0] BOOTROM_BASE = 16'hfc00;
  localparam logic [7:0] BOOT_VECTOR_RESET = 8'hfc;
  localparam logic [7:0] STATUS_RESET = 8'hff;
  localparam logic [7:0] START_LOW = 8'h00;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] REC_DATA = 8'h00;
  localparam logic [7:0] REC_EOF = 8'h01;
  localparam logic [7:0] REC_OSC = 8'h02;
  localparam logic [7:0] REC_WRITE = 8'h03;
  localparam logic [7:0] REC_DISPLAY = 8'h04;
  localparam logic [7:0] SUB_ERASE_BV = 8'h04;
  localparam logic [7:0] SUB_PROG_BV = 8'h06;
  localparam int MAX_DATA = 16;
  localparam int HDR_BYTES = 4;
  localparam int BAUD_W = 16;
endpackage

// File: isp_uart.sv
// Purpose: autobaud receiver and transmitter
// Assumes: idle-high serial line, 8N1
// Notes: bit time measured on the start bit of the first character
`timescale 1ns/1ps
module isp_uart
  import isp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic rxd,
  output logic txd,
  isp_uart_if.serial u
);
  logic [15:0] bit_q, bit_d, rcnt_q, rcnt_d, tcnt_q, tcnt_d;
  logic lock_q, lock_d, rbusy_q, rbusy_d, tbusy_q, tbusy_d, rxp_q;
  logic [3:0] ridx_q, ridx_d, tidx_q, tidx_d;
  logic [7:0] rsh_q, rsh_d;
  logic [9:0] tsh_q, tsh_d;
  logic rv_q, rv_d, txd_q, txd_d;
  always_comb begin
    bit_d = bit_q; lock_d = lock_q; rcnt_d = rcnt_q; rbusy_d = rbusy_q;
    ridx_d = ridx_q; rsh_d = rsh_q; rv_d = 1'b0;
    tcnt_d = tcnt_q; tbusy_d = tbusy_q; tidx_d = tidx_q; tsh_d = tsh_q; txd_d = txd_q;
    if (!lock_q) begin
      // start bit of 'U' is one low bit; its width sets the rate
      if (!rxd) rcnt_d = rcnt_q + 16'h0001;
      else if (rxp_q == 1'b0 && rcnt_q != 16'h0000) begin
        bit_d = rcnt_q;
        lock_d = 1'b1;
        // already inside data bit 0; half a bit lands the first sample mid-bit
        rcnt_d = {1'b0, rcnt_q[15:1]};
        rbusy_d = 1'b1;
        ridx_d = 4'h1;
      end
    end else if (!rbusy_q) begin
      if (!rxd) begin
        rbusy_d = 1'b1; ridx_d = 4'h0; rcnt_d = {1'b0, bit_q[15:1]};
      end
    end else if (rcnt_q >= bit_q - 16'h0001) begin
      rcnt_d = 16'h0000;
      ridx_d = ridx_q + 4'h1;
      if (ridx_q >= 4'h1 && ridx_q <= 4'h8) rsh_d = {rxd, rsh_q[7:1]};
      if (ridx_q == 4'h9) begin
        rbusy_d = 1'b0; rv_d = 1'b1;
      end
    end else rcnt_d = rcnt_q + 16'h0001;
    if (!tbusy_q) begin
      if (u.tx_start && lock_q) begin
        tbusy_d = 1'b1; tsh_d = {1'b1, u.tx_data, 1'b0}; tidx_d = 4'h0; tcnt_d = 16'h0000;
      end
    end else if (tcnt_q == 16'h0000) begin
      // reload one short so a bit lasts exactly the measured count
      txd_d = tsh_q[0]; tsh_d = {1'b1, tsh_q[9:1]}; tcnt_d = bit_q - 16'h0001;
      tidx_d = tidx_q + 4'h1;
      if (tidx_q == 4'ha) begin
        tbusy_d = 1'b0; txd_d = 1'b1;
      end
    end else tcnt_d = tcnt_q - 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bit_q <= 16'h0000; lock_q <= 1'b0; rcnt_q <= 16'h0000; rbusy_q <= 1'b0;
      ridx_q <= 4'h0; rsh_q <= 8'h00; rv_q <= 1'b0; rxp_q <= 1'b1;
      tcnt_q <= 16'h0000; tbusy_q <= 1'b0; tidx_q <= 4'h0; tsh_q <= 10'h3ff; txd_q <= 1'b1;
    end else begin
      bit_q <= bit_d; lock_q <= lock_d; rcnt_q <= rcnt_d; rbusy_q <= rbusy_d;
      ridx_q <= ridx_d; rsh_q <= rsh_d; rv_q <= rv_d; rxp_q <= rxd;
      tcnt_q <= tcnt_d; tbusy_q <= tbusy_d; tidx_q <= tidx_d; tsh_q <= tsh_d; txd_q <= txd_d;
    end
  end
  assign txd = txd_q;
  assign u.rx_data = rsh_q;
  assign u.rx_valid = rv_q;
  // registered only: start is built from busy, so feeding it back would loop
  assign u.tx_busy = tbusy_q;
  assign u.bit_cycles = bit_q;
  assign u.baud_locked = lock_q;
endmodule

// File: isp_uart_if.sv
// Purpose: byte carrier between loader core and serial engine
// Assumes: single clock
// Notes: rx_valid is a one-cycle pulse
`timescale 1ns/1ps
interface isp_uart_if;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_start;
  logic tx_busy;
  logic [15:0] bit_cycles;
  logic baud_locked;
  modport serial (output rx_data, rx_valid, tx_busy, bit_cycles, baud_locked,
                  input tx_data, tx_start);
  modport core (input rx_data, rx_valid, tx_busy, bit_cycles, baud_locked,
                output tx_data, tx_start);
endinterface
